// file: rtl/lldb_sup.sv
// Leased-line supervisor with dial backup, lamps and profile store
// Function
// - Originate: delay, off-hook, tone wait, handshake
// - DTR-ignore option skips the DTR requirement
// - Synchronous port rate follows line rate
// - Async fixed rate keeps last autobaud rate
// - Break or two failed retrains: failure, lamp off
// - Wait 20-30 s, off-hook, dial slot 3
// - Unconnected backup call retried every 45-60 s
// - Backup lamp flashes during dial backup
// - Key, DTR drop, hang-up return to leased line
// - Retrain lowers speed unless fallback disabled
// - Speed lamps show current link speed
// - Fallback off holds the forced speed
// - Profile 7: originate sync four-wire, no backup
// - Profile 11: answer complement, no backup
// - Profiles 8 and 9: with dial backup
// - Loaded profile acts only after power cycle
// - Profile write locations 0-3, default 0
// - Backup profile dials 10-15 s after failure
// - Answer side flashes lamp on ring
// - Setting raised by two enables backup
// - Call role zero selects originate side
`timescale 1ns/1ps
`default_nettype none
`include "lldb_sup_cfg.svh"
module lldb_sup
  import lldb_sup_pkg::*;
#(
  parameter int TICK_CYCLES = `SUP_CLK_HZ
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lldb_pins_type line_pins,
  input wire logic [2:0] line_rate,
  input wire logic autobaud_valid,
  input wire logic [3:0] autobaud_rate,
  output logic off_hook,
  output logic pstn_select,
  output logic originate_mode,
  output logic handshake_start,
  output logic dial_start,
  output logic answer_call,
  output logic [31:0] dial_number,
  output logic carrier_detect_indicator,
  output logic backup_link_lamp,
  output logic auto_answer_lamp,
  output logic [2:0] link_speed_lamp,
  output logic [3:0] port_rate
);
  localparam int HALF_CYCLES = TICK_CYCLES / 2;

  lldb_state_type state_r, state_nxt;
  lldb_cfg_type edit_cfg_r, active_cfg_r;
  lldb_cfg_type slot_r [4];
  lldb_pins_type s1_r, s2_r, s3_r, filt_r, filt_q_r;
  logic [31:0] half_cnt_r;
  logic flash_r;
  logic sec_tick;
  logic [5:0] sec_cnt_r;
  logic [1:0] fail_cnt_r;
  logic [2:0] speed_r;
  logic [2:0] forced_speed_r;
  logic [3:0] autobaud_r;
  logic [7:0] bkset_r;
  logic [31:0] number_r;
  logic [5:0] ring_hold_r;
  logic wr_en, rd_en;
  logic ev_ring, ev_retrain_fail, ev_retrain_ok, ev_carrier_up, ev_carrier_down;
  logic ev_key, ev_dtr_drop, ev_esc, ev_call_fail, ev_leased_up;
  logic restart_req, dtr_ok, answer_side, failed, restore_req, connected;
  logic [5:0] fail_wait_s;

  // APB: no wait states, but a frozen block holds the master off
  assign pready = clk_en;
  assign wr_en = psel & penable & pwrite & clk_en;
  assign rd_en = psel & penable & ~pwrite;

  // Three-stage input filter; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < $bits(lldb_pins_type); gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          filt_r[gi] <= 1'b0;
          filt_q_r[gi] <= 1'b0;
        end else if (clk_en) begin
          s1_r[gi] <= line_pins[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            filt_r[gi] <= s3_r[gi];
          end
          filt_q_r[gi] <= filt_r[gi];
        end
      end
    end
  endgenerate

  // Edge events of the filtered line inputs
  assign ev_ring = filt_r.ring & ~filt_q_r.ring;
  assign ev_retrain_fail = filt_r.retrain_fail & ~filt_q_r.retrain_fail;
  assign ev_retrain_ok = filt_r.retrain_ok & ~filt_q_r.retrain_ok;
  assign ev_carrier_up = filt_r.carrier & ~filt_q_r.carrier;
  assign ev_carrier_down = ~filt_r.carrier & filt_q_r.carrier;
  assign ev_key = filt_r.data_key & ~filt_q_r.data_key;
  assign ev_dtr_drop = ~filt_r.dtr & filt_q_r.dtr;
  assign ev_esc = filt_r.esc_hangup & ~filt_q_r.esc_hangup;
  assign ev_call_fail = filt_r.call_fail & ~filt_q_r.call_fail;
  assign ev_leased_up = filt_r.leased_sense & ~filt_q_r.leased_sense;

  // Half-second flash phase; one seconds tick per full flash period
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      half_cnt_r <= 32'h0;
      flash_r <= 1'b0;
    end else if (clk_en) begin
      if (half_cnt_r >= 32'(HALF_CYCLES - 1)) begin
        half_cnt_r <= 32'h0;
        flash_r <= ~flash_r;
      end else begin
        half_cnt_r <= half_cnt_r + 32'h1;
      end
    end
  end
  assign sec_tick = flash_r && (half_cnt_r >= 32'(HALF_CYCLES - 1));

  // Role and failure decode
  assign answer_side = active_cfg_r.call_role_select;
  assign dtr_ok = filt_r.dtr | active_cfg_r.dtr_ignore_option;
  assign failed = ev_carrier_down | (fail_cnt_r >= `SUP_FAIL_LIMIT);
  assign restore_req = ev_key | ev_dtr_drop | ev_esc;
  assign connected = (state_r == ST_LEASED) || (state_r == ST_BACKUP);
  // Backup profile shortens the wait before dialling
  assign fail_wait_s = active_cfg_r.quick_backup ? `SUP_FAIL_QUICK_S : `SUP_FAIL_WAIT_S;
  assign restart_req = wr_en && psel && (paddr == `SUP_OFF_RESTART);

  // Supervisor sequence
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_POWERUP: begin
        if (sec_cnt_r >= `SUP_PWRUP_S) begin
          state_nxt = ST_WAIT_TONE;
        end
      end
      ST_WAIT_TONE: begin
        // Originate waits for answer tone; answer side sends it
        if (dtr_ok && (answer_side || filt_r.answer_tone)) begin
          state_nxt = ST_HANDSHAKE;
        end
      end
      ST_HANDSHAKE: begin
        if (filt_r.carrier) begin
          state_nxt = ST_LEASED;
        end else if (!dtr_ok) begin
          state_nxt = ST_WAIT_TONE;
        end
      end
      ST_LEASED: begin
        if (failed) begin
          if (!active_cfg_r.backup_en) begin
            state_nxt = ST_WAIT_TONE;
          end else if (answer_side) begin
            state_nxt = ST_RING_WAIT;
          end else begin
            state_nxt = ST_FAIL_WAIT;
          end
        end
      end
      ST_FAIL_WAIT: begin
        if (sec_cnt_r >= fail_wait_s) begin
          state_nxt = ST_DIAL;
        end
      end
      ST_DIAL: begin
        if (filt_r.carrier) begin
          state_nxt = ST_BACKUP;
        end else if (ev_call_fail || sec_cnt_r >= `SUP_CALL_TIMEOUT_S) begin
          state_nxt = answer_side ? ST_RING_WAIT : ST_RETRY_WAIT;
        end
      end
      ST_BACKUP: begin
        if (restore_req) begin
          state_nxt = ST_ONHOOK;
        end else if (failed) begin
          state_nxt = answer_side ? ST_RING_WAIT : ST_RETRY_WAIT;
        end
      end
      ST_RETRY_WAIT: begin
        if (ev_leased_up) begin
          state_nxt = ST_ONHOOK;
        end else if (sec_cnt_r >= `SUP_RETRY_S) begin
          state_nxt = ST_DIAL;
        end
      end
      ST_ONHOOK: begin
        if (sec_cnt_r >= `SUP_ONHOOK_S) begin
          state_nxt = ST_WAIT_TONE;
        end
      end
      ST_RING_WAIT: begin
        // Answer side picks up the incoming backup call
        if (ev_ring) begin
          state_nxt = ST_DIAL;
        end else if (ev_leased_up) begin
          state_nxt = ST_WAIT_TONE;
        end
      end
      default: state_nxt = ST_POWERUP;
    endcase
    // Soft power cycle restarts the whole sequence
    if (restart_req) begin
      state_nxt = ST_POWERUP;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_POWERUP;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Seconds in the current state; restarts on every state change
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sec_cnt_r <= 6'h0;
    end else if (clk_en) begin
      if (state_nxt != state_r || restart_req) begin
        sec_cnt_r <= 6'h0;
      end else if (sec_tick && sec_cnt_r != 6'h3f) begin
        sec_cnt_r <= sec_cnt_r + 6'h1;
      end
    end
  end

  // Failed-retrain count; a new connection starts it afresh
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fail_cnt_r <= 2'h0;
    end else if (clk_en) begin
      if (!connected || state_nxt != state_r) begin
        fail_cnt_r <= 2'h0;
      end else if (ev_retrain_ok) begin
        fail_cnt_r <= 2'h0;
      end else if (ev_retrain_fail && fail_cnt_r < `SUP_FAIL_LIMIT) begin
        fail_cnt_r <= fail_cnt_r + 2'h1;
      end
    end
  end

  // Link speed: taken at connect, lowered or forced on retrain
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      speed_r <= 3'h0;
    end else if (clk_en) begin
      if (ev_carrier_up) begin
        speed_r <= active_cfg_r.speed_fallback_off ? forced_speed_r : line_rate;
      end else if (connected && ev_retrain_ok) begin
        if (active_cfg_r.speed_fallback_off) begin
          speed_r <= forced_speed_r;
        end else if (speed_r != 3'h0) begin
          speed_r <= speed_r - 3'h1;
        end
      end
    end
  end

  // Rate found by the most recent autobaud
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      autobaud_r <= 4'h0;
    end else if (clk_en && autobaud_valid) begin
      autobaud_r <= autobaud_rate;
    end
  end

  // Ring flash hold for the auto-answer lamp
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ring_hold_r <= 6'h0;
    end else if (clk_en) begin
      if (ev_ring && answer_side) begin
        ring_hold_r <= `SUP_RING_FLASH_S;
      end else if (sec_tick && ring_hold_r != 6'h0) begin
        ring_hold_r <= ring_hold_r - 6'h1;
      end
    end
  end

  // Editable configuration, backup setting, forced speed and number
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      edit_cfg_r <= `SUP_CFG_RST;
      bkset_r <= 8'h0;
      forced_speed_r <= 3'h0;
      number_r <= 32'h0;
    end else if (clk_en && wr_en) begin
      unique case (paddr)
        `SUP_OFF_CFG: edit_cfg_r[6:0] <= pwdata[6:0];
        `SUP_OFF_BKSET: begin
          bkset_r <= pwdata[7:0];
          if (pwdata[7:0] == bkset_r + `SUP_BKSET_STEP) begin
            edit_cfg_r.backup_en <= 1'b1;
          end
        end
        `SUP_OFF_FSPEED: forced_speed_r <= pwdata[2:0];
        `SUP_OFF_NUMBER: number_r <= pwdata;
        `SUP_OFF_FACTORY: begin
          // Loads only the editable copy; nothing changes until restart
          unique case (pwdata[3:0])
            `SUP_PROF_ORIG_LEASED_NUM: edit_cfg_r <= `SUP_PROF_ORIG_LEASED;
            `SUP_PROF_ANS_LEASED_NUM: edit_cfg_r <= `SUP_PROF_ANS_LEASED;
            `SUP_PROF_ORIG_BACKUP_NUM: edit_cfg_r <= `SUP_PROF_ORIG_BACKUP;
            `SUP_PROF_ANS_BACKUP_NUM: edit_cfg_r <= `SUP_PROF_ANS_BACKUP;
            default: edit_cfg_r <= edit_cfg_r;
          endcase
        end
        default: edit_cfg_r <= edit_cfg_r;
      endcase
    end
  end

  // Stored profiles; location defaults to 0 when none is given
  generate
    for (gi = 0; gi < 4; gi++) begin : g_slot
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          slot_r[gi] <= `SUP_CFG_RST;
        end else if (clk_en && wr_en && paddr == `SUP_OFF_PWRITE) begin
          if ((pwdata[`SUP_PW_LOC_GIVEN] ? pwdata[1:0] : 2'h0) == 2'(gi)) begin
            slot_r[gi] <= edit_cfg_r;
          end
        end
      end
    end
  endgenerate

  // Active configuration recalled from location 0 on power cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      active_cfg_r <= `SUP_CFG_RST;
    end else if (clk_en && restart_req) begin
      active_cfg_r <= slot_r[0];
    end
  end

  // Line control strobes; pulses last one cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      handshake_start <= 1'b0;
      dial_start <= 1'b0;
      answer_call <= 1'b0;
    end else if (clk_en) begin
      handshake_start <= (state_r == ST_WAIT_TONE) && (state_nxt == ST_HANDSHAKE);
      dial_start <= (state_nxt == ST_DIAL) && (state_r != ST_DIAL) && !answer_side;
      answer_call <= (state_r == ST_RING_WAIT) && (state_nxt == ST_DIAL);
    end
  end

  // Hook relay, line relay and lamps, all registered
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      off_hook <= 1'b0;
      pstn_select <= 1'b0;
      originate_mode <= 1'b1;
      dial_number <= 32'h0;
      carrier_detect_indicator <= 1'b0;
      backup_link_lamp <= 1'b0;
      auto_answer_lamp <= 1'b0;
      link_speed_lamp <= 3'h0;
      port_rate <= 4'h0;
    end else if (clk_en) begin
      off_hook <= !(state_nxt inside {ST_POWERUP, ST_FAIL_WAIT, ST_RETRY_WAIT, ST_ONHOOK, ST_RING_WAIT});
      pstn_select <= state_nxt inside {ST_DIAL, ST_BACKUP};
      originate_mode <= !answer_side;
      dial_number <= number_r;
      carrier_detect_indicator <= connected && filt_r.carrier;
      // Flash on backup, steady on for a synchronous leased link
      backup_link_lamp <= (state_r == ST_BACKUP) ? flash_r :
                          (state_r == ST_LEASED) && active_cfg_r.sync_mode;
      auto_answer_lamp <= (ring_hold_r != 6'h0) ? flash_r : answer_side;
      link_speed_lamp <= connected ? speed_r : 3'h0;
      if (active_cfg_r.sync_mode) begin
        port_rate <= {1'b0, speed_r};
      end else if (active_cfg_r.fixed_port_rate_option) begin
        port_rate <= autobaud_r;
      end else begin
        port_rate <= autobaud_rate;
      end
    end
  end

  // Read data; unmapped addresses answer with an error
  always_comb begin
    prdata = 32'h0;
    pslverr = 1'b0;
    if (psel && penable) begin
      unique case (paddr)
        `SUP_OFF_CFG: prdata = {24'h0, edit_cfg_r};
        `SUP_OFF_BKSET: prdata = {24'h0, bkset_r};
        `SUP_OFF_FSPEED: prdata = {29'h0, forced_speed_r};
        `SUP_OFF_NUMBER: prdata = number_r;
        `SUP_OFF_FACTORY, `SUP_OFF_PWRITE, `SUP_OFF_RESTART: prdata = 32'h0;
        `SUP_OFF_STATUS: begin
          if (rd_en) begin
            prdata = {16'h0, pstn_select, off_hook, port_rate, speed_r, fail_cnt_r, filt_r.carrier, state_r};
          end
        end
        `SUP_OFF_ACTIVE: prdata = {24'h0, active_cfg_r};
        default: pslverr = 1'b1;
      endcase
    end
  end
endmodule : lldb_sup
`default_nettype wire

// file: include/lldb_sup_cfg.svh
// Constants for the leased-line dial-backup supervisor
`ifndef LLDB_SUP_CFG_SVH
`define LLDB_SUP_CFG_SVH
// Register byte offsets
`define SUP_OFF_CFG 8'h00
`define SUP_OFF_BKSET 8'h04
`define SUP_OFF_FSPEED 8'h08
`define SUP_OFF_NUMBER 8'h0c
`define SUP_OFF_FACTORY 8'h10
`define SUP_OFF_PWRITE 8'h14
`define SUP_OFF_RESTART 8'h18
`define SUP_OFF_STATUS 8'h1c
`define SUP_OFF_ACTIVE 8'h20
// Field positions
`define SUP_PW_LOC_GIVEN 2
`define SUP_BKSET_STEP 8'h02
// Configuration reset value and factory profiles
`define SUP_CFG_RST 8'h00
`define SUP_PROF_ORIG_LEASED_NUM 4'h7
`define SUP_PROF_ORIG_BACKUP_NUM 4'h8
`define SUP_PROF_ANS_BACKUP_NUM 4'h9
`define SUP_PROF_ANS_LEASED_NUM 4'hb
`define SUP_PROF_ORIG_LEASED 8'h30
`define SUP_PROF_ANS_LEASED 8'h31
`define SUP_PROF_ORIG_BACKUP 8'hf0
`define SUP_PROF_ANS_BACKUP 8'hf1
// Timing, figures in seconds and clock rate in hertz; failed-retrain limit as a count
`define SUP_CLK_HZ 40000000
`define SUP_PWRUP_S 6'd4
`define SUP_FAIL_WAIT_S 6'd25
`define SUP_FAIL_QUICK_S 6'd12
`define SUP_RETRY_S 6'd50
`define SUP_ONHOOK_S 6'd1
`define SUP_CALL_TIMEOUT_S 6'd40
`define SUP_RING_FLASH_S 6'd2
`define SUP_FAIL_LIMIT 2'd2
`endif

// file: include/lldb_sup_pkg.sv
// Types for the leased-line dial-backup supervisor
package lldb_sup_pkg;
  typedef enum logic [3:0] {
    ST_POWERUP = 4'b0000,
    ST_WAIT_TONE = 4'b0001,
    ST_HANDSHAKE = 4'b0010,
    ST_LEASED = 4'b0011,
    ST_FAIL_WAIT = 4'b0100,
    ST_DIAL = 4'b0101,
    ST_BACKUP = 4'b0110,
    ST_RETRY_WAIT = 4'b0111,
    ST_ONHOOK = 4'b1000,
    ST_RING_WAIT = 4'b1001
  } lldb_state_type;
  // Configuration word, bit 7 downward
  typedef struct packed {
    logic backup_en;
    logic quick_backup;
    logic sync_mode;
    logic four_wire;
    logic speed_fallback_off;
    logic fixed_port_rate_option;
    logic dtr_ignore_option;
    logic call_role_select;
  } lldb_cfg_type;
  // Line-side inputs arriving from outside the clock domain
  typedef struct packed {
    logic leased_sense;
    logic call_fail;
    logic esc_hangup;
    logic data_key;
    logic ring;
    logic retrain_ok;
    logic retrain_fail;
    logic carrier;
    logic answer_tone;
    logic dtr;
  } lldb_pins_type;
endpackage : lldb_sup_pkg

// file: bench/lldb_sup_properties.sv
// Port-level timing checks for the supervisor
`timescale 1ns/1ps
`default_nettype none
`include "lldb_sup_cfg.svh"
module lldb_sup_properties
  import lldb_sup_pkg::*;
#(
  parameter int TICK_CYCLES = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire lldb_pins_type line_pins,
  input wire logic off_hook,
  input wire logic pstn_select,
  input wire logic dial_start,
  input wire logic [31:0] dial_number,
  input wire logic carrier_detect_indicator,
  input wire logic backup_link_lamp,
  input wire logic [2:0] link_speed_lamp
);
  logic [31:0] up_cnt;
  logic [31:0] gap_cnt;
  logic hook_q;
  logic [31:0] num_r;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // Cycles since reset release, saturating
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) up_cnt <= 32'h0;
    else if (up_cnt != 32'hffffffff) up_cnt <= up_cnt + 32'h1;
  end
  // Length of the latest on-hook spell, held once off-hook again
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hook_q <= 1'b0;
      gap_cnt <= 32'h0;
    end else begin
      hook_q <= off_hook;
      if (!off_hook && hook_q) gap_cnt <= 32'h1;
      else if (!off_hook && gap_cnt != 32'hffffffff) gap_cnt <= gap_cnt + 32'h1;
    end
  end
  // Shadow of the stored backup number, taken at the committing edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) num_r <= 32'h0;
    else if (psel && penable && pready && pwrite && paddr == `SUP_OFF_NUMBER) num_r <= pwdata;
  end
  sequence bk_still;
    pstn_select && carrier_detect_indicator && $stable(backup_link_lamp);
  endsequence
  powerup_hold_a: assert property (off_hook |-> up_cnt >= 3 * TICK_CYCLES)
    else $error("off-hook too soon after power-up");
  powerup_late_a: assert property (up_cnt == 5 * TICK_CYCLES |-> off_hook)
    else $error("still on-hook after power-up delay");
  dial_gap_a: assert property (dial_start |-> gap_cnt >= 10 * TICK_CYCLES && gap_cnt <= 60 * TICK_CYCLES)
    else $error("on-hook spell before dialling out of range");
  dial_slot_a: assert property (dial_start |-> dial_number == num_r)
    else $error("dialled number differs from stored one");
  carrier_lamp_a: assert property ($fell(line_pins.carrier) && carrier_detect_indicator
    |-> ##[1:10] !carrier_detect_indicator)
    else $error("carrier lamp stayed on after break");
  speed_clear_a: assert property ($fell(carrier_detect_indicator) |-> ##[0:2] link_speed_lamp == 3'h0)
    else $error("speed lamps lit while offline");
  backup_flash_a: assert property (not (bk_still [*8]))
    else $error("backup lamp not flashing");
  key_onhook_a: assert property ($rose(line_pins.data_key) && pstn_select && carrier_detect_indicator
    |-> ##[1:10] !off_hook)
    else $error("key press did not hang up backup call");
endmodule : lldb_sup_properties
`default_nettype wire

// file: bench/lldb_sup_far_model.sv
// Far answer modem: answer tone, carrier and refused calls
`timescale 1ns/1ps
`default_nettype none
module lldb_sup_far_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic off_hook,
  input wire logic pstn_select,
  input wire logic handshake_start,
  input wire logic dial_start,
  input wire logic leased_up,
  input wire logic refuse,
  input wire logic [3:0] lag,
  output logic answer_tone,
  output logic carrier,
  output logic call_fail
);
  logic [3:0] cnt_r;
  logic arm_r;
  logic hook_q;
  logic [2:0] fail_r;
  // Tone only while the leased pair is intact and the unit sits on it
  assign answer_tone = leased_up && off_hook && !pstn_select;
  // Carrier follows a handshake or an answered call after a lag
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      arm_r <= 1'b0;
      cnt_r <= 4'h0;
      hook_q <= 1'b0;
      carrier <= 1'b0;
    end else begin
      hook_q <= off_hook;
      if ((handshake_start && leased_up) || (dial_start && !refuse)) begin
        arm_r <= 1'b1;
        cnt_r <= lag;
      end else if ((hook_q && !off_hook) || (!pstn_select && !leased_up)) begin
        arm_r <= 1'b0;
        carrier <= 1'b0;
      end else if (arm_r && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (arm_r) begin
        carrier <= 1'b1;
      end
    end
  end
  // A refused call reports failure long enough to pass the filter
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) fail_r <= 3'h0;
    else if (dial_start && refuse) fail_r <= 3'h6;
    else if (fail_r != 3'h0) fail_r <= fail_r - 3'h1;
  end
  assign call_fail = fail_r != 3'h0;
endmodule : lldb_sup_far_model
`default_nettype wire

// file: bench/lldb_sup_tb.sv
// Self-checking bench for the supervisor with the far-modem model
`timescale 1ns/1ps
`default_nettype none
`include "lldb_sup_cfg.svh"
module lldb_sup_tb
  import lldb_sup_pkg::*;
;
  localparam int TK = 8;
  logic sys_clk, nrst, clk_en, psel, penable, pwrite, autobaud_valid, err, b;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, dial_number, rd;
  logic pready, pslverr, off_hook, pstn_select, originate_mode, handshake_start, dial_start, answer_call;
  logic carrier_detect_indicator, backup_link_lamp, auto_answer_lamp;
  logic [2:0] line_rate, link_speed_lamp;
  logic [3:0] autobaud_rate, port_rate, lag;
  lldb_pins_type tp, line_pins;
  logic tone, car, cfail, leased_up, refuse;
  logic [31:0] fc [5] = '{32'h7, 32'hb, 32'h9, 32'h5, 32'h8};
  logic [31:0] fx [5] = '{`SUP_PROF_ORIG_LEASED, `SUP_PROF_ANS_LEASED, `SUP_PROF_ANS_BACKUP,
                          `SUP_PROF_ANS_BACKUP, `SUP_PROF_ORIG_BACKUP};
  int n_errors = 0;
  int check_count = 0;
  int c, cyc = 0, t0;
  // Far-modem lines merged into the pin bundle
  always_comb begin
    line_pins = tp;
    line_pins.answer_tone = tone;
    line_pins.carrier = car;
    line_pins.call_fail = cfail;
  end
  lldb_sup #(.TICK_CYCLES(TK)) dut (.sys_clk, .nrst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .line_pins, .line_rate, .autobaud_valid, .autobaud_rate, .off_hook,
    .pstn_select, .originate_mode, .handshake_start, .dial_start, .answer_call, .dial_number,
    .carrier_detect_indicator, .backup_link_lamp, .auto_answer_lamp, .link_speed_lamp, .port_rate);
  lldb_sup_far_model far (.sys_clk, .nrst, .off_hook, .pstn_select, .handshake_start, .dial_start,
    .leased_up, .refuse, .lag, .answer_tone(tone), .carrier(car), .call_fail(cfail));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : cmp
  // One APB transfer; an idle edge follows so strobes never toggle twice at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    cmp(nm, ex, rd);
  endtask : rdchk
  task automatic st(input string nm, input lldb_state_type s);
    apb(1'b0, `SUP_OFF_STATUS, 32'h0);
    cmp(nm, {28'h0, s}, {28'h0, rd[3:0]});
  endtask : st
  task automatic waitv(ref logic s, input logic v);
    c = 0;
    while (s !== v) begin
      @(posedge sys_clk);
      c++;
    end
  endtask : waitv
  // Pin events held past the input filter
  task automatic pulse(input int k);
    tp[k] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    tp[k] <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : pulse
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  initial begin
    repeat (4000) @(posedge sys_clk);
    n_errors++;
    conclude();
  end
  initial begin
    {nrst, clk_en, psel, penable, pwrite, autobaud_valid} = 6'h10;
    {paddr, pwdata, autobaud_rate} = 44'h0;
    tp = 10'h000;
    {line_rate, lag, leased_up, refuse} = 9'h56;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    t0 = cyc;
    @(posedge sys_clk);
    cmp("originate_mode", 1, originate_mode);
    rdchk("cfg_reset", `SUP_OFF_CFG, 32'h0);
    rdchk("active_reset", `SUP_OFF_ACTIVE, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    cmp("unmapped_err", 32'h1, {rd[30:0], err});
    waitv(off_hook, 1'b1);
    cmp("powerup_delay", 1, (cyc - t0) inside {[3*TK:5*TK+2]});
    repeat (16) @(posedge sys_clk);
    st("tone_needs_dtr", ST_WAIT_TONE);
    tp.dtr <= 1'b1;
    waitv(carrier_detect_indicator, 1'b1);
    st("leased_online", ST_LEASED);
    leased_up <= 1'b0;
    waitv(carrier_detect_indicator, 1'b0);
    cmp("break_lamp_off", 1, c <= 10);
    repeat (4) @(posedge sys_clk);
    st("no_backup_retone", ST_WAIT_TONE);
    leased_up <= 1'b1;
    waitv(carrier_detect_indicator, 1'b1);
    apb(1'b1, `SUP_OFF_BKSET, 32'h1);
    rdchk("bkset_odd", `SUP_OFF_CFG, 32'h0);
    apb(1'b1, `SUP_OFF_BKSET, 32'h3);
    rdchk("bkset_plus2", `SUP_OFF_CFG, 32'h80);
    foreach (fc[i]) begin
      apb(1'b1, `SUP_OFF_FACTORY, fc[i]);
      rdchk("factory_cfg", `SUP_OFF_CFG, fx[i]);
    end
    apb(1'b1, `SUP_OFF_NUMBER, 32'h97832535);
    apb(1'b1, `SUP_OFF_PWRITE, 32'h7);
    apb(1'b1, `SUP_OFF_RESTART, 32'h0);
    rdchk("slot3_not_boot", `SUP_OFF_ACTIVE, 32'h0);
    apb(1'b1, `SUP_OFF_PWRITE, 32'h0);
    rdchk("load_waits_cycle", `SUP_OFF_ACTIVE, 32'h0);
    line_rate <= 3'h5;
    apb(1'b1, `SUP_OFF_RESTART, 32'h0);
    rdchk("slot0_default", `SUP_OFF_ACTIVE, `SUP_PROF_ORIG_BACKUP);
    waitv(carrier_detect_indicator, 1'b1);
    repeat (2) @(posedge sys_clk);
    cmp("sync_port_rate", 4'h5, port_rate);
    cmp("speed_lamp", 3'h5, link_speed_lamp);
    pulse(4);
    cmp("retrain_slower", 3'h4, link_speed_lamp);
    refuse <= 1'b1;
    pulse(3);
    cmp("one_fail_online", 1, carrier_detect_indicator);
    pulse(3);
    cmp("two_fails_drop", 0, carrier_detect_indicator);
    leased_up <= 1'b0;
    waitv(dial_start, 1'b1);
    cmp("quick_dial_delay", 1, c inside {[10*TK-8:15*TK]});
    repeat (2) @(posedge sys_clk);
    cmp("dial_on_pstn", 1, off_hook && pstn_select);
    cmp("dial_slot3", 32'h97832535, dial_number);
    refuse <= 1'b0;
    lag <= 4'hc;
    waitv(dial_start, 1'b1);
    cmp("retry_period", 1, c inside {[45*TK:61*TK]});
    waitv(carrier_detect_indicator, 1'b1);
    st("backup_online", ST_BACKUP);
    c = 0;
    b = backup_link_lamp;
    repeat (16) begin
      @(posedge sys_clk);
      if (backup_link_lamp !== b) c++;
      b = backup_link_lamp;
    end
    cmp("backup_flash", 1, c >= 3);
    leased_up <= 1'b1;
    tp.data_key <= 1'b1;
    waitv(off_hook, 1'b0);
    cmp("key_hangs_up", 1, c <= 10);
    tp.data_key <= 1'b0;
    waitv(off_hook, 1'b1);
    cmp("onhook_brief", 1, c inside {[2:TK+1]});
    cmp("back_on_leased", 0, pstn_select);
    waitv(carrier_detect_indicator, 1'b1);
    conclude();
  end
endmodule : lldb_sup_tb
bind lldb_sup lldb_sup_properties #(.TICK_CYCLES(TICK_CYCLES)) props (.sys_clk, .nrst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .line_pins, .off_hook, .pstn_select, .dial_start, .dial_number,
  .carrier_detect_indicator, .backup_link_lamp, .link_speed_lamp);
`default_nettype wire
